// ===== soi_pkg.sv
// Purpose: shared types and constants of the safety output interlock
// Assumes: 20 MHz clock, synchronous active-high reset
// Notes:   long counts are overridable as top-level parameters
package soi_pkg;

  localparam int unsigned CLK_HZ   = 20_000_000;
  localparam int unsigned CLK_MHZ  = CLK_HZ / 1_000_000;
  localparam int unsigned MS_CYC   = CLK_HZ / 1000;
  localparam int unsigned SEC_CYC  = CLK_HZ;

  // off-pulse self-test
  localparam int unsigned PULSE_US        = 300;
  localparam int unsigned PULSE_CYC       = PULSE_US * CLK_MHZ;
  localparam int unsigned TEST_PERIOD_MS  = 100;
  localparam int unsigned TEST_PERIOD_CYC = TEST_PERIOD_MS * MS_CYC;
  localparam logic [3:0]  CHECK_CYC       = 4'h8;

  // operator reset input
  localparam int unsigned RST_MIN_MS  = 500;
  localparam int unsigned RST_MIN_CYC = RST_MIN_MS * MS_CYC;
  localparam logic [5:0]  RST_MAX_S   = 6'h1e;
  localparam logic [2:0]  RDLY_MIN_S  = 3'h1;
  localparam logic [2:0]  RDLY_MAX_S  = 3'h6;

  // synchronised pin vector layout
  localparam int PIN_W     = 11;
  localparam int PIN_RST   = 0;
  localparam int PIN_FB    = 1;
  localparam int PIN_MUTE  = 3;
  localparam int PIN_RB    = 7;

  typedef enum logic [2:0] {
    ZS_BOOT  = 3'h0,
    ZS_IDLE  = 3'h1,
    ZS_DELAY = 3'h2,
    ZS_RUN   = 3'h3,
    ZS_HOLD  = 3'h4
  } soi_zone_t;

  typedef enum logic [1:0] {
    MS_IDLE  = 2'h0,
    MS_FIRST = 2'h1,
    MS_ON    = 2'h2,
    MS_WAIT  = 2'h3
  } soi_mute_t;

  typedef struct packed {
    logic       dual;       // dual protection mode
    logic       start_ilk;  // start interlock
    logic       restart_ilk;// manual restart
    logic [2:0] rdly_s;     // restart delay, seconds
    logic       fb_en;      // feedback monitoring
    logic [7:0] fb_on_ms;   // judge delay, outputs on
    logic [7:0] fb_off_ms;  // judge delay, outputs off
  } soi_cfg_t;

  typedef struct packed {
    logic       order;      // 0: a then b, 1: b then a
    logic [1:0] win_sel;    // 1, 3, 5, 10 s
    logic [1:0] max_sel;    // 1, 6, 12 min, unlimited
  } soi_mute_cfg_t;

  typedef struct packed {
    logic [1:0] zone_clear;   // protection zone clear
    logic [1:0] warn_clear;   // warning zone clear
    logic [1:0] obj_outside;  // object outside muting zone
    logic       area_change;  // area switched
    logic       int_fault;    // internal system error
  } soi_scan_t;

  function automatic logic [3:0] win_sec(input logic [1:0] sel);
    case (sel)
      2'h0:    win_sec = 4'h1;
      2'h1:    win_sec = 4'h3;
      2'h2:    win_sec = 4'h5;
      default: win_sec = 4'ha;
    endcase
  endfunction

  // zero means unlimited
  function automatic logic [9:0] max_sec(input logic [1:0] sel);
    case (sel)
      2'h0:    max_sec = 10'h03c;
      2'h1:    max_sec = 10'h168;
      2'h2:    max_sec = 10'h2d0;
      default: max_sec = 10'h000;
    endcase
  endfunction

endpackage

// ===== soi_fb_mon.sv
// Purpose: machine feedback monitor for one safety pair
// Assumes: fb already synchronised, ms_tick one cycle per millisecond
// Notes:   fault is sticky until cleared with a matching input
`timescale 1ns/100ps
module soi_fb_mon
  import soi_pkg::*;
(
  input  wire logic       clock,   // system clock
  input  wire logic       reset,   // sync reset
  input  wire logic       en,      // monitoring enabled
  input  wire logic       cmd,     // commanded pair state
  input  wire logic       fb,      // feedback contact level
  input  wire logic       ms_tick, // millisecond tick
  input  wire logic [7:0] on_ms,   // delay while on
  input  wire logic [7:0] off_ms,  // delay while off
  input  wire logic       clr,     // clear request
  output logic            fault    // feedback fault
);
  typedef struct packed {
    logic [7:0] cnt;
    logic       last;
    logic       fault;
  } soi_fb_st_t;

  soi_fb_st_t st_r;
  soi_fb_st_t st_nxt;
  logic       mis;
  logic [7:0] dly;

  always_comb begin
    st_nxt = st_r;
    mis = en & (fb == cmd);
    dly = cmd ? on_ms : off_ms;
    st_nxt.last = cmd;
    if (clr && !mis) begin
      st_nxt.fault = 1'b0;
    end
    if (cmd != st_r.last || !mis) begin
      st_nxt.cnt = 8'h00;
    end else begin
      if (ms_tick && st_r.cnt != 8'hff) begin
        st_nxt.cnt = st_r.cnt + 8'h01;
      end
      if (st_r.cnt > dly) begin
        st_nxt.fault = 1'b1;
      end
    end
  end

  always_ff @(posedge clock) begin
    if (reset) begin
      st_r <= '0;
    end else begin
      st_r <= st_nxt;
    end
  end

  assign fault = st_r.fault;
endmodule

// ===== soi_mute.sv
// Purpose: one two-input muting channel
// Assumes: inputs synchronised, sec_tick one cycle per second
// Notes:   after any stop both inputs must drop before re-arming
`timescale 1ns/100ps
module soi_mute
  import soi_pkg::*;
#(
  parameter int unsigned SEC_CYCLES = SEC_CYC
)(
  input  wire logic          clock,    // system clock
  input  wire logic          reset,    // sync reset
  input  wire soi_mute_cfg_t cfg,      // channel settings
  input  wire logic          in_a,     // first muting input
  input  wire logic          in_b,     // second muting input
  input  wire logic          allow,    // zone clear, outputs on
  input  wire logic          stop,     // external stop cause
  input  wire logic          sec_tick, // one-second tick
  output logic               active    // muting in force
);
  typedef struct packed {
    soi_mute_t   fsm;
    logic [31:0] cyc;
    logic [9:0]  secs;
    logic        act;
  } soi_mt_st_t;

  soi_mt_st_t  st_r;
  soi_mt_st_t  st_nxt;
  logic        first;
  logic        second;
  logic [31:0] win_cyc;
  logic [9:0]  lim;

  always_comb begin
    st_nxt  = st_r;
    first   = cfg.order ? in_b : in_a;
    second  = cfg.order ? in_a : in_b;
    win_cyc = 32'(win_sec(cfg.win_sel) * SEC_CYCLES);
    lim     = max_sec(cfg.max_sel);
    unique case (st_r.fsm)
      MS_IDLE: begin
        if (first && second) begin
          st_nxt.fsm = MS_WAIT;
        end else if (first && allow) begin
          st_nxt.fsm = MS_FIRST;
          st_nxt.cyc = 32'h0000_0000;
        end
      end
      MS_FIRST: begin
        st_nxt.cyc = st_r.cyc + 32'h0000_0001;
        if (!first) begin
          st_nxt.fsm = MS_IDLE;
        end else if (st_r.cyc >= win_cyc || !allow || stop) begin
          st_nxt.fsm = MS_WAIT;
        end else if (second) begin
          st_nxt.fsm  = MS_ON;
          st_nxt.act  = 1'b1;
          st_nxt.secs = 10'h000;
        end
      end
      MS_ON: begin
        if (sec_tick) begin
          st_nxt.secs = st_r.secs + 10'h001;
        end
        if (!in_a || !in_b || stop ||
            (lim != 10'h000 && st_r.secs >= lim)) begin
          st_nxt.fsm = MS_WAIT;
          st_nxt.act = 1'b0;
        end
      end
      MS_WAIT: begin
        if (!in_a && !in_b) begin
          st_nxt.fsm = MS_IDLE;
        end
      end
    endcase
  end

  always_ff @(posedge clock) begin
    if (reset) begin
      st_r <= '{fsm: MS_IDLE, default: '0};
    end else begin
      st_r <= st_nxt;
    end
  end

  assign active = st_r.act;
endmodule

// ===== soi_interlock.sv
// Purpose: safety switching outputs with self-test, lockout,
//          restart interlock, feedback monitoring and muting
// Assumes: scanner status comes from logic on the same clock;
//          reset pin, feedback, muting and readback are raw pins
// Notes:   zone b drives the secondary pair only in dual mode
//
// Notes on behaviour
// - each active primary output, and secondary in dual mode, is pulsed off for 300 us as self-test.
// - single mode pulses only the primary pair.
// - self-test error enters lockout, all safety and alert outputs off.
// - only power-on reset leaves lockout.
// - without restart interlock outputs return once zone is clear.
// - lockout keeps outputs off whatever the interlock setting.
// - manual restart keeps outputs off until a valid reset.
// - reset pulse must exceed 500 ms to count.
// - after valid reset outputs turn on after 1 to 6 s delay.
// - reset ignored while an internal fault is present.
// - reset held beyond 30 s is a hardware malfunction.
// - start interlock holds outputs off; request shown when ready.
// - start interlock reset with clear zone turns on after delay.
// - feedback fault turns outputs off, with on and off delays.
// - dual mode checks second feedback against secondary pair.
// - muting takes effect within 60 ms and overrides detection.
// - muting starts with clear zone, outputs on, ordered inputs.
// - order selectable; pairing window 1, 3, 5 or 10 s.
// - input off, timeout, outside object, error or area ends muting.
// - maximum muting 1, 6, 12 minutes or unlimited.
// - dual mode adds a second independent muting channel.
`timescale 1ns/100ps
module soi_interlock
  import soi_pkg::*;
#(
  parameter int unsigned PULSE_CYCLES  = PULSE_CYC,
  parameter int unsigned PERIOD_CYCLES = TEST_PERIOD_CYC,
  parameter int unsigned MS_CYCLES     = MS_CYC,
  parameter int unsigned SEC_CYCLES    = SEC_CYC,
  parameter int unsigned RST_CYCLES    = RST_MIN_CYC
)(
  input  wire logic               clock,                 // 20 MHz
  input  wire logic               reset,                 // power-on
  input  wire soi_cfg_t           cfg,                   // settings
  input  wire soi_mute_cfg_t [1:0] mute_cfg,             // per channel
  input  wire soi_scan_t          scan,                  // scan status
  input  wire logic               reset_in,              // reset pin
  input  wire logic [1:0]         machine_feedback_in,   // a, b
  input  wire logic [3:0]         mute_in,               // 4 inputs
  input  wire logic [3:0]         readback,              // pair levels
  output logic [1:0]              safety_pair_primary,   // pair a
  output logic [1:0]              safety_pair_secondary, // pair b
  output logic                    zone_alert_out_a,      // warning a
  output logic                    zone_alert_out_b,      // warning b
  output logic [1:0]              restart_request_out,   // ready
  output logic [1:0]              mute_active,           // muting
  output logic                    lockout_out,           // locked
  output logic                    reset_fault_out        // reset stuck
);
  typedef struct packed {
    logic [PIN_W-1:0]  s1;
    logic [PIN_W-1:0]  s2;
    logic [PIN_W-1:0]  s3;
    logic [PIN_W-1:0]  filt;
    logic [31:0]       ms_cnt;
    logic              ms_tick;
    logic [31:0]       sec_cnt;
    logic              sec_tick;
    logic [31:0]       test_cnt;
    logic              pulse;
    logic              init_done;
    logic [3:0]        drv;
    logic [3:0][3:0]   mis;
    logic [1:0]        alert;
    logic              lockout;
    logic [31:0]       rst_cnt;
    logic [5:0]        rst_sec;
    logic              rst_valid;
    logic              rst_fault;
    soi_zone_t [1:0]   zst;
    logic [1:0][31:0]  dly;
    logic [1:0]        req;
    logic [1:0]        cmd;
  } soi_top_st_t;

  soi_top_st_t      st_r;
  soi_top_st_t      st_nxt;
  logic [1:0]       fb_fault;
  logic [1:0]       mute_act;
  logic [1:0]       zfault;
  logic [1:0]       permit;
  logic [1:0]       on;
  logic             on_sec;
  logic [2:0]       rsel;
  logic [31:0]      rdly;
  logic             rin;
  logic [PIN_W-1:0] agree;

  // restart delay in cycles, clamped to the legal range
  function automatic logic [31:0] delay_cyc(input logic [2:0] s);
    logic [2:0] v;
    v = s;
    if (v < RDLY_MIN_S) begin
      v = RDLY_MIN_S;
    end
    if (v > RDLY_MAX_S) begin
      v = RDLY_MAX_S;
    end
    delay_cyc = 32'(32'(v) * SEC_CYCLES);
  endfunction

  always_comb begin
    st_nxt = st_r;
    // pin synchroniser; second and third stage must agree
    st_nxt.s1   = {readback, mute_in, machine_feedback_in, reset_in};
    st_nxt.s2   = st_r.s1;
    st_nxt.s3   = st_r.s2;
    agree       = ~(st_r.s2 ^ st_r.s3);
    st_nxt.filt = (agree & st_r.s3) | (~agree & st_r.filt);
    rin         = st_r.filt[PIN_RST];

    st_nxt.ms_tick  = (st_r.ms_cnt == 32'(MS_CYCLES - 1));
    st_nxt.ms_cnt   = st_nxt.ms_tick ? 32'h0 : st_r.ms_cnt + 32'h1;
    st_nxt.sec_tick = (st_r.sec_cnt == 32'(SEC_CYCLES - 1));
    st_nxt.sec_cnt  = st_nxt.sec_tick ? 32'h0 : st_r.sec_cnt + 32'h1;

    st_nxt.test_cnt = st_r.test_cnt + 32'h1;
    if (!st_r.pulse && st_r.test_cnt == 32'(PERIOD_CYCLES - 1)) begin
      st_nxt.pulse    = 1'b1;
      st_nxt.test_cnt = 32'h0;
    end else if (st_r.pulse &&
                 st_r.test_cnt == 32'(PULSE_CYCLES - 1)) begin
      st_nxt.pulse     = 1'b0;
      st_nxt.test_cnt  = 32'h0;
      st_nxt.init_done = 1'b1;
    end

    st_nxt.rst_valid = 1'b0;
    if (rin) begin
      if (st_r.rst_cnt != 32'(RST_CYCLES)) begin
        st_nxt.rst_cnt = st_r.rst_cnt + 32'h1;
      end
      if (st_r.sec_tick && st_r.rst_sec != RST_MAX_S) begin
        st_nxt.rst_sec = st_r.rst_sec + 6'h01;
      end
      if (st_r.rst_sec == RST_MAX_S) begin
        st_nxt.rst_fault = 1'b1;
      end
    end else begin
      st_nxt.rst_valid = (st_r.rst_cnt == 32'(RST_CYCLES)) &
                         ~st_r.rst_fault;
      st_nxt.rst_cnt   = 32'h0;
      st_nxt.rst_sec   = 6'h00;
    end

    // readback must follow the driven level
    for (int i = 0; i < 4; i++) begin
      if (st_r.filt[PIN_RB+i] != st_r.drv[i]) begin
        if (st_r.mis[i] != CHECK_CYC) begin
          st_nxt.mis[i] = st_r.mis[i] + 4'h1;
        end
      end else begin
        st_nxt.mis[i] = 4'h0;
      end
      if (st_r.mis[i] == CHECK_CYC) begin
        st_nxt.lockout = 1'b1;
      end
    end
    // only the power-on reset clears this
    if (st_r.rst_fault) begin
      st_nxt.lockout = 1'b1;
    end

    rsel = cfg.rdly_s;
    rdly = delay_cyc(rsel);
    for (int z = 0; z < 2; z++) begin
      zfault[z] = scan.int_fault | fb_fault[z] | st_r.lockout;
      permit[z] = scan.zone_clear[z] | mute_act[z];
      // request only when ready to accept
      st_nxt.req[z] = (st_r.zst[z] == ZS_IDLE) & st_r.init_done &
                      ~zfault[z];
      unique case (st_r.zst[z])
        ZS_BOOT: begin
          if (st_r.init_done) begin
            st_nxt.zst[z] = cfg.start_ilk ? ZS_IDLE : ZS_HOLD;
          end
        end
        ZS_IDLE: begin
          if (st_r.rst_valid && scan.zone_clear[z] && !zfault[z]) begin
            st_nxt.zst[z] = ZS_DELAY;
            st_nxt.dly[z] = rdly;
          end
        end
        ZS_DELAY: begin
          st_nxt.dly[z] = st_r.dly[z] - 32'h1;
          if (!scan.zone_clear[z] || zfault[z]) begin
            st_nxt.zst[z] = ZS_IDLE;
          end else if (st_r.dly[z] <= 32'h1) begin
            st_nxt.zst[z] = ZS_RUN;
          end
        end
        ZS_RUN: begin
          if (!permit[z] || zfault[z]) begin
            st_nxt.zst[z] = cfg.restart_ilk ? ZS_IDLE : ZS_HOLD;
          end
        end
        ZS_HOLD: begin
          if (scan.zone_clear[z] && !zfault[z]) begin
            st_nxt.zst[z] = ZS_RUN;
          end
        end
        default: begin
          st_nxt.zst[z] = ZS_BOOT;
        end
      endcase
      on[z] = (st_r.zst[z] == ZS_RUN) & ~zfault[z];
    end

    on_sec = cfg.dual ? on[1] : on[0];
    st_nxt.cmd = {on_sec, on[0]};
    st_nxt.drv[1:0] = {2{on[0] & ~st_r.pulse}};
    // secondary pulsed in dual mode only
    st_nxt.drv[3:2] = {2{on_sec & ~(st_r.pulse & cfg.dual)}};
    st_nxt.alert = scan.warn_clear & {2{~st_r.lockout}};
    if (st_r.lockout) begin
      st_nxt.drv = 4'h0;
      st_nxt.req = 2'h0;
    end
  end

  always_ff @(posedge clock) begin
    if (reset) begin
      st_r <= '{zst: '{ZS_BOOT, ZS_BOOT}, default: '0};
    end else begin
      st_r <= st_nxt;
    end
  end

  genvar g;
  generate
    for (g = 0; g < 2; g++) begin : g_zone
      // one monitor per pair, the second for the secondary pair
      soi_fb_mon u_fb (
        .clock   (clock),
        .reset   (reset),
        .en      (cfg.fb_en & ((g == 0) | cfg.dual)),
        .cmd     (st_r.cmd[g]),
        .fb      (st_r.filt[PIN_FB+g]),
        .ms_tick (st_r.ms_tick),
        .on_ms   (cfg.fb_on_ms),
        .off_ms  (cfg.fb_off_ms),
        // cleared one cycle ahead so the same reset restarts the zone
        .clr     (st_nxt.rst_valid),
        .fault   (fb_fault[g])
      );
      soi_mute #(
        .SEC_CYCLES (SEC_CYCLES)
      ) u_mute (
        .clock    (clock),
        .reset    (reset),
        .cfg      (mute_cfg[g]),
        .in_a     (st_r.filt[PIN_MUTE+2*g]),
        .in_b     (st_r.filt[PIN_MUTE+2*g+1]),
        .allow    (scan.zone_clear[g] & on[g] & ((g == 0) | cfg.dual)),
        .stop     (scan.obj_outside[g] | zfault[g] | scan.area_change),
        .sec_tick (st_r.sec_tick),
        .active   (mute_act[g])
      );
    end
  endgenerate

  assign safety_pair_primary   = st_r.drv[1:0];
  assign safety_pair_secondary = st_r.drv[3:2];
  assign zone_alert_out_a      = st_r.alert[0];
  assign zone_alert_out_b      = st_r.alert[1];
  assign restart_request_out   = st_r.req;
  assign mute_active           = mute_act;
  assign lockout_out           = st_r.lockout;
  assign reset_fault_out       = st_r.rst_fault;
endmodule

// ===== soi_interlock_assertions.sv
// Purpose: port checks of the safety output interlock
// Assumes: one clock, sync active-high reset
// Notes:   bound to every soi_interlock instance
`timescale 1ns/100ps
module soi_interlock_assertions
  import soi_pkg::*;
#(
  parameter int unsigned PULSE_CYCLES = PULSE_CYC
)(
  input wire logic                clock,                 // clock
  input wire logic                reset,                 // reset
  input wire soi_cfg_t            cfg,                   // settings
  input wire soi_mute_cfg_t [1:0] mute_cfg,              // muting cfg
  input wire soi_scan_t           scan,                  // scan status
  input wire logic                reset_in,              // reset pin
  input wire logic [1:0]          machine_feedback_in,   // feedback
  input wire logic [3:0]          mute_in,               // muting pins
  input wire logic [3:0]          readback,              // readback
  input wire logic [1:0]          safety_pair_primary,   // pair a
  input wire logic [1:0]          safety_pair_secondary, // pair b
  input wire logic                zone_alert_out_a,      // alert a
  input wire logic                zone_alert_out_b,      // alert b
  input wire logic [1:0]          restart_request_out,   // ready
  input wire logic [1:0]          mute_active,           // muting
  input wire logic                lockout_out,           // locked
  input wire logic                reset_fault_out        // reset stuck
);
  typedef struct packed {
    logic [15:0] off;
  } soi_chk_t;
  soi_chk_t st_r;
  soi_chk_t st_nxt;
  // length of the current off phase of pair a
  always_comb begin
    st_nxt = st_r;
    if (safety_pair_primary[0])
      st_nxt.off = 16'h0000;
    else if (st_r.off != 16'hffff)
      st_nxt.off = st_r.off + 16'h0001;
  end
  always_ff @(posedge clock) begin
    if (reset)
      st_r <= '0;
    else
      st_r <= st_nxt;
  end
  default clocking cb @(posedge clock); endclocking
  default disable iff (reset);
  a_lock_all_off: assert property (
    lockout_out && $past(lockout_out) |-> safety_pair_primary == 2'h0 &&
    safety_pair_secondary == 2'h0 && !zone_alert_out_a &&
    !zone_alert_out_b && restart_request_out == 2'h0)
    else $error("outputs active in lockout");
  a_lock_sticky: assert property (
    lockout_out |=> lockout_out) else $error("lockout released");
  a_pulse_len: assert property (
    $rose(safety_pair_primary[0]) |-> int'(st_r.off) >= PULSE_CYCLES)
    else $error("off phase shorter than test pulse");
  a_pair_same: assert property (
    safety_pair_primary[0] == safety_pair_primary[1] &&
    safety_pair_secondary[0] == safety_pair_secondary[1])
    else $error("pair outputs differ");
  a_stuck_lock: assert property (
    $rose(reset_fault_out) |-> ##[0:2] lockout_out)
    else $error("stuck reset without lockout");
  a_no_on_lock: assert property (
    $rose(safety_pair_primary[0]) |-> !$past(lockout_out))
    else $error("outputs on in lockout");
  a_mute_start: assert property (
    $rose(mute_active[0]) |-> $past(mute_in[0], 4) && $past(mute_in[1], 4))
    else $error("muting without both inputs");
  a_mute_drop: assert property (
    $fell(mute_in[0]) && mute_active[0] |-> ##[1:8] !mute_active[0])
    else $error("muting kept after input drop");
  a_mute_single: assert property (
    !cfg.dual |-> !mute_active[1]) else $error("channel b muting in single");
  c_mute: cover property ($rose(mute_active[0]));
  c_lock: cover property ($rose(lockout_out));
  c_stuck: cover property ($rose(reset_fault_out));
endmodule

bind soi_interlock soi_interlock_assertions #(
  .PULSE_CYCLES(PULSE_CYCLES)
) i_chk (
  .clock(clock), .reset(reset), .cfg(cfg), .mute_cfg(mute_cfg),
  .scan(scan), .reset_in(reset_in),
  .machine_feedback_in(machine_feedback_in), .mute_in(mute_in),
  .readback(readback), .safety_pair_primary(safety_pair_primary),
  .safety_pair_secondary(safety_pair_secondary),
  .zone_alert_out_a(zone_alert_out_a), .zone_alert_out_b(zone_alert_out_b),
  .restart_request_out(restart_request_out), .mute_active(mute_active),
  .lockout_out(lockout_out), .reset_fault_out(reset_fault_out)
);

// ===== soi_machine.sv
// Purpose: controlled machine: contactors with feedback contacts
// Assumes: one cycle contact lag
// Notes:   stuck and fb_bad inject contact faults
`timescale 1ns/100ps
module soi_machine
  import soi_pkg::*;
(
  input  wire logic       clock,    // system clock
  input  wire logic [1:0] pri,      // primary pair
  input  wire logic [1:0] sec,      // secondary pair
  input  wire logic       stuck,    // primary contact stuck off
  input  wire logic [1:0] fb_bad,   // wrong feedback a, b
  output logic      [3:0] readback, // contact levels
  output logic      [1:0] fb        // feedback contacts
);
  typedef struct packed {
    logic [3:0] rb;
    logic [1:0] fb;
  } soi_mach_t;
  soi_mach_t st_r;
  soi_mach_t st_nxt;
  always_comb begin
    st_nxt.rb = {sec, pri & {2{~stuck}}};
    st_nxt.fb = ~{sec[0], pri[0]} ^ fb_bad;
  end
  always_ff @(posedge clock) begin
    st_r <= st_nxt;
  end
  assign readback = st_r.rb;
  assign fb       = st_r.fb;
endmodule

// ===== soi_interlock_tb.sv
// Purpose: self-checking bench of the safety output interlock
// Assumes: shortened counts, 1 s = 100 cycles
// Notes:   readback and feedback come from the machine model
`timescale 1ns/100ps
module soi_interlock_tb
  import soi_pkg::*;
;
  localparam int P = 20;
  logic                clock = 1'b0;
  logic                reset = 1'b1;
  soi_cfg_t            cfg;
  soi_mute_cfg_t [1:0] mc;
  soi_scan_t           scan;
  logic                rin;
  logic                stuck;
  logic [1:0]          fbad;
  logic [3:0]          mi;
  logic [3:0]          rb;
  logic [1:0]          fb;
  logic [1:0]          pri;
  logic [1:0]          sec;
  logic [1:0]          req;
  logic [1:0]          mact;
  logic                za;
  logic                zb;
  logic                lk;
  logic                rf;
  logic [6:0]          w;
  int                  error_cnt = 0;
  int                  cmp_count = 0;
  assign w = {mact[1], lk, rf, mact[0], req[0], sec[0], pri[0]};
  always #25 clock = ~clock;
  soi_interlock #(.PULSE_CYCLES(P), .PERIOD_CYCLES(200), .MS_CYCLES(10),
    .SEC_CYCLES(100), .RST_CYCLES(30)) i_dut (
    .clock(clock), .reset(reset), .cfg(cfg), .mute_cfg(mc), .scan(scan),
    .reset_in(rin), .machine_feedback_in(fb), .mute_in(mi), .readback(rb),
    .safety_pair_primary(pri), .safety_pair_secondary(sec),
    .zone_alert_out_a(za), .zone_alert_out_b(zb),
    .restart_request_out(req), .mute_active(mact), .lockout_out(lk),
    .reset_fault_out(rf));
  soi_machine i_mach (.clock(clock), .pri(pri), .sec(sec), .stuck(stuck),
    .fb_bad(fbad), .readback(rb), .fb(fb));
  task automatic finish_test();
    $display("compares %0d errors %0d", cmp_count, error_cnt);
    if (error_cnt == 0 && cmp_count > 0)
      $display("SIMULATION PASSED");
    else
      $display("SIMULATION FAILED");
    $finish;
  endtask
  task automatic chk(input logic [7:0] g, input logic [7:0] e);
    cmp_count++;
    if (g !== e) begin
      error_cnt++;
      $display("ERROR t=%0t got=%h exp=%h", $time, g, e);
    end
  endtask
  // bounded wait for w[i] == v, sampled mid-cycle
  task automatic wt(input int i, input logic v, input int n);
    int k;
    k = 0;
    @(negedge clock);
    while (w[i] !== v && k < n) begin
      @(negedge clock);
      k++;
    end
    chk(8'(w[i]), 8'(v));
    if (w[i] !== v)
      finish_test();
    @(posedge clock);
  endtask
  task automatic lowrun(input int i, input int n, output int m);
    int r;
    r = 0;
    m = 0;
    repeat (n) begin
      @(negedge clock);
      r = (w[i] === 1'b1) ? 0 : r + 1;
      if (r > m)
        m = r;
    end
    @(posedge clock);
  endtask
  task automatic press(input int n);
    rin <= 1'b1;
    repeat (n) @(posedge clock);
    rin <= 1'b0;
    @(posedge clock);
  endtask
  initial begin
    int m;
    cfg = '{dual:1'b1, start_ilk:1'b1, restart_ilk:1'b1, rdly_s:3'h2,
            fb_en:1'b1, fb_on_ms:8'h03, fb_off_ms:8'h03};
    mc = '0;
    mc[1].order = 1'b1;
    scan = '{zone_clear:2'h3, warn_clear:2'h3, obj_outside:2'h0,
             area_change:1'b0, int_fault:1'b0};
    rin = 1'b0;
    stuck = 1'b0;
    fbad = 2'h0;
    mi = 4'h0;
    repeat (16) @(posedge clock);
    reset <= 1'b0;
    wt(2, 1'b1, 400);
    chk({za, zb, pri, sec}, 8'h30);
    press(20);
    repeat (300) @(posedge clock);
    chk(8'(pri), 8'h00);
    press(40);
    repeat (150) @(posedge clock);
    chk(8'(pri), 8'h00);
    wt(0, 1'b1, 120);
    wt(1, 1'b1, 20);
    lowrun(0, 250, m);
    chk(8'(m), 8'(P));
    lowrun(1, 250, m);
    chk(8'(m), 8'(P));
    cfg.dual <= 1'b0;
    lowrun(1, 250, m);
    chk(8'(m), 8'h00);
    cfg.dual <= 1'b1;
    mi <= 4'h9;
    repeat (20) @(posedge clock);
    mi <= 4'hf;
    wt(3, 1'b1, 20);
    wt(6, 1'b1, 5);
    scan.zone_clear <= 2'h2;
    lowrun(0, 250, m);
    chk(8'(m), 8'(P));
    mi[0] <= 1'b0;
    wt(3, 1'b0, 20);
    wt(0, 1'b0, 50);
    chk(8'(w[6]), 8'h01);
    scan.area_change <= 1'b1;
    wt(6, 1'b0, 20);
    scan.area_change <= 1'b0;
    mi <= 4'h0;
    scan.zone_clear <= 2'h3;
    repeat (300) @(posedge clock);
    chk(8'(pri), 8'h00);
    press(40);
    wt(0, 1'b1, 400);
    for (int j = 0; j < 2; j++) begin
      fbad <= 2'h1 << j;
      wt(j, 1'b0, 100);
      fbad <= 2'h0;
      repeat (50) @(posedge clock);
      press(40);
      wt(j, 1'b1, 400);
    end
    scan.int_fault <= 1'b1;
    wt(0, 1'b0, 100);
    press(40);
    repeat (300) @(posedge clock);
    chk(8'(pri), 8'h00);
    scan.int_fault <= 1'b0;
    repeat (20) @(posedge clock);
    press(40);
    wt(0, 1'b1, 400);
    cfg.restart_ilk <= 1'b0;
    scan.zone_clear <= 2'h0;
    wt(0, 1'b0, 100);
    repeat (P) @(posedge clock);
    scan.zone_clear <= 2'h3;
    wt(0, 1'b1, 400);
    press(3100);
    wt(4, 1'b1, 10);
    wt(5, 1'b1, 10);
    press(40);
    repeat (50) @(posedge clock);
    chk(8'(lk), 8'h01);
    reset <= 1'b1;
    repeat (16) @(posedge clock);
    reset <= 1'b0;
    wt(5, 1'b0, 5);
    wt(2, 1'b1, 400);
    press(40);
    wt(0, 1'b1, 400);
    stuck <= 1'b1;
    wt(5, 1'b1, 50);
    stuck <= 1'b0;
    repeat (2) @(posedge clock);
    chk({pri, sec, za, zb, req}, 8'h00);
    repeat (400) @(posedge clock);
    chk(8'(pri), 8'h00);
    finish_test();
  end
endmodule
